// ---- lin_mode_ctrl.sv ----
// Mode control and transmit supervision of a LIN transceiver with regulator.
// Notes on behaviour
// (R1) Enable high selects Normal, both paths active; code ignores enable in Sleep.
// (R2) Enable falls, transmit high: Silent, regulator on.
// (R3) Enable falls, transmit low: Sleep, regulator off.
// (R4) Floating enable reads low, driver recessive.
// (R5) Local wake leaves Sleep or Silent.
// (R6) Normal: dominant only while transmit low.
// (R7) Low transmit at Normal entry blocks driver; code does not block on entry from Fail-Safe, where transmit reads high.
// (R8) Fail-Safe turns transmit pin into output.
// (R9) Transmit low over 20 ms forces recessive.
// (R10) Re-arm after timeout needs 10 us high.
// (R11) Sleep/Silent choice uses real transmit level.
// (R12) Overtemperature disables driver, regulator unaffected.
// (R13) Bus short allows sleep; release wakes.
// (R14) Supply undervoltage disables transmission.
// (R15) Power-up starts Fail-Safe, regulator enabled.
// (R16) Regulator undervoltage asserts internal reset.
// (R17) Fail-Safe source coded on transmit/receive pins.
// (R18) Filtered local wake enters Fail-Safe, transmit low.
// (R19) Silent: receive high; Normal: receive follows bus.
// (R20) Timebase measures durations; inputs synchronised.
module lin_mode_ctrl import lin_mode_pkg::*; #(
    parameter int unsigned DOM_LIMIT = DOM_CYCLES,
    parameter int unsigned REARM_LIMIT = REARM_CYCLES,
    parameter int unsigned WAKE_LIMIT = WAKE_CYCLES
) (
    // Clock and power-on reset.
    input wire logic i_clk,
    input wire logic i_resetn,
    // Host pins.
    input wire logic i_enable,
    input wire logic i_txd,
    output logic o_txd,
    output logic o_txd_oe_n,
    output logic o_rxd,
    // Wake pin and bus receiver.
    input wire logic i_local_wake_input,
    input wire logic i_bus_rx,
    // Analog comparators.
    input wire analog_t i_analog,
    // Bus driver, regulator and reset outputs.
    output logic o_bus_drive_dom,
    output logic o_vreg_on,
    output logic o_internal_reset_n
);

    mode_t mode_r;
    mode_t mode_nxt;
    fs_src_t src_r;
    analog_t ana_s;
    logic en_s;
    logic txd_s;
    logic wk_s;
    logic bus_s;
    logic en_d_r;
    logic wk_d_r;
    logic wk_armed_r;
    logic tx_blocked_r;
    logic dom_to;
    logic rearm_ok;
    logic wk_held;
    logic bus_dom_long;
    logic txd_pin;
    logic en_fall;
    logic wk_fall;

    // The transmit pin reads high when released in Fail-Safe (pull-up).
    assign txd_pin = (mode_r == MODE_FAILSAFE) ? 1'b1 : i_txd; // R8

    // Every pin and comparator is synchronised before use.
    lin_sync2 #(.W(4), .RST_VAL(4'b0111)) u_sync_pins (
        .i_clk(i_clk),
        .i_resetn(i_resetn),
        .i_async({i_enable, txd_pin, i_local_wake_input, i_bus_rx}), // R20
        .o_sync({en_s, txd_s, wk_s, bus_s})
    );
    lin_sync2 #(.W(3), .RST_VAL(3'b010)) u_sync_ana (
        .i_clk(i_clk),
        .i_resetn(i_resetn),
        .i_async(i_analog), // R20
        .o_sync(ana_s)
    );

    // Dominant timeout on the transmit input.
    lin_duration #(.LIMIT(DOM_LIMIT)) u_dom (
        .i_clk(i_clk),
        .i_resetn(i_resetn),
        .i_level(!txd_s), // R9
        .o_done(dom_to)
    );
    // High time of the transmit input that re-arms the driver.
    lin_duration #(.LIMIT(REARM_LIMIT)) u_rearm (
        .i_clk(i_clk),
        .i_resetn(i_resetn),
        .i_level(txd_s), // R7 R10
        .o_done(rearm_ok)
    );
    // Local wake filter.
    lin_duration #(.LIMIT(WAKE_LIMIT)) u_wake (
        .i_clk(i_clk),
        .i_resetn(i_resetn),
        .i_level(!wk_s && wk_armed_r), // R18
        .o_done(wk_held)
    );
    // Bus wake filter; a short that is released also counts.
    lin_duration #(.LIMIT(WAKE_LIMIT)) u_bus_wake (
        .i_clk(i_clk),
        .i_resetn(i_resetn),
        .i_level(!bus_s),
        .o_done(bus_dom_long)
    );

    assign en_fall = en_d_r && !en_s;
    assign wk_fall = wk_d_r && !wk_s;

    // Edge history of enable and the wake pin.
    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            en_d_r <= 1'b0; // R4
            wk_d_r <= 1'b1;
        end else begin
            en_d_r <= en_s;
            wk_d_r <= wk_s;
        end
    end

    // A local wake needs a falling edge before the low level is filtered.
    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            wk_armed_r <= 1'b0;
        end else if (wk_s) begin
            wk_armed_r <= 1'b0;
        end else if (wk_fall) begin
            wk_armed_r <= 1'b1;
        end else if (wk_held && mode_r != MODE_SLEEP
                     && mode_r != MODE_SILENT) begin
            wk_armed_r <= 1'b0;
        end
    end

    // Mode selection.
    always_comb begin
        mode_nxt = mode_r;
        case (mode_r)
            MODE_FAILSAFE: begin
                if (!o_internal_reset_n) begin
                    mode_nxt = MODE_FAILSAFE;
                end else if (en_s && !ana_s.supply_uv) begin
                    mode_nxt = MODE_NORMAL; // R1
                end else if (en_fall) begin
                    mode_nxt = txd_s ? MODE_SILENT : MODE_SLEEP;
                end
            end
            MODE_NORMAL: begin
                if (en_fall) begin
                    // Raw level decides, even after a timeout.
                    mode_nxt = txd_s ? MODE_SILENT : MODE_SLEEP; // R2 R3 R11
                end else if (ana_s.supply_uv) begin
                    mode_nxt = MODE_FAILSAFE; // R14
                end
            end
            MODE_SILENT: begin
                if (en_s) begin
                    mode_nxt = MODE_NORMAL; // R1
                end else if (wk_held || bus_dom_long && bus_s
                             || ana_s.vreg_uv) begin
                    mode_nxt = MODE_FAILSAFE; // R5 R13
                end
            end
            MODE_SLEEP: begin
                if (wk_held || bus_dom_long && bus_s) begin
                    mode_nxt = MODE_FAILSAFE; // R5 R13
                end
            end
            default: mode_nxt = MODE_FAILSAFE;
        endcase
    end

    // Mode register; power-up lands in Fail-Safe.
    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            mode_r <= MODE_FAILSAFE; // R15
        end else begin
            mode_r <= mode_nxt;
        end
    end

    // Fail-Safe source flags; a new event wins over the clear.
    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            src_r <= '0;
        end else begin
            if (mode_nxt == MODE_NORMAL && en_s) begin
                src_r <= '0; // R17
            end
            if (wk_held && mode_r != MODE_NORMAL) begin
                src_r.local_wake <= 1'b1; // R18
            end
            if (bus_dom_long && bus_s && (mode_r == MODE_SLEEP
                || mode_r == MODE_SILENT)) begin
                src_r.bus_wake <= 1'b1; // R13
            end
            if (ana_s.supply_uv && mode_r == MODE_NORMAL) begin
                src_r.supply_uv <= 1'b1;
            end
        end
    end

    // Driver block: set on Normal entry with low transmit or on timeout.
    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            tx_blocked_r <= 1'b1;
        end else if (mode_r != MODE_NORMAL && mode_nxt == MODE_NORMAL) begin
            tx_blocked_r <= !txd_s; // R7
        end else if (dom_to) begin
            tx_blocked_r <= 1'b1; // R9
        end else if (rearm_ok) begin
            tx_blocked_r <= 1'b0; // R10
        end
    end

    // Bus driver gating.
    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            o_bus_drive_dom <= 1'b0;
        end else begin
            o_bus_drive_dom <= mode_r == MODE_NORMAL && !txd_s // R6
                && !tx_blocked_r && !dom_to // R7 R9
                && !ana_s.over_temp // R12
                && !ana_s.supply_uv; // R14
        end
    end

    // Regulator and internal reset; overtemperature leaves them alone.
    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            o_vreg_on <= 1'b1; // R15
            o_internal_reset_n <= 1'b0;
        end else begin
            o_vreg_on <= mode_nxt != MODE_SLEEP; // R2 R3 R12
            o_internal_reset_n <= !ana_s.vreg_uv; // R16
        end
    end

    // Receive pin and transmit pin direction.
    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            o_rxd <= 1'b1;
            o_txd <= 1'b1;
            o_txd_oe_n <= 1'b1;
        end else begin
            case (mode_nxt)
                MODE_NORMAL: o_rxd <= bus_s; // R19
                MODE_FAILSAFE: o_rxd <= !(src_r.bus_wake
                    || src_r.supply_uv); // R17
                default: o_rxd <= 1'b1; // R19
            endcase
            o_txd_oe_n <= mode_nxt != MODE_FAILSAFE; // R8
            o_txd <= !(src_r.bus_wake || src_r.local_wake); // R17 R18
        end
    end

endmodule

// ---- lin_mode_pkg.sv ----
// Package with constants, states and carrier types of the LIN mode control.
package lin_mode_pkg;

    // Clock rate of the internal timebase in hertz.
    localparam int unsigned CLK_HZ = 50_000_000;

    // Times in their own units, as specified.
    localparam int unsigned TXD_REARM_US = 10;
    localparam int unsigned DOM_TIMEOUT_MS = 20;
    localparam int unsigned WAKE_FILTER_US = 100;

    // Re-arm and timeout are least times; cycles per unit divide exactly at this clock, no rounding.
    localparam int unsigned REARM_CYCLES =
        (TXD_REARM_US * (CLK_HZ / 1_000_000));
    localparam int unsigned DOM_CYCLES =
        (DOM_TIMEOUT_MS * (CLK_HZ / 1_000));
    localparam int unsigned WAKE_CYCLES =
        (WAKE_FILTER_US * (CLK_HZ / 1_000_000));

    // Width of the shared duration counters.
    localparam int unsigned CNT_W = 21;

    // Reset values of the pin synchronisers (pull-down on enable).
    localparam logic SYNC_RST_LOW = 1'b0;
    localparam logic SYNC_RST_HIGH = 1'b1;

    // Operating modes, one-hot.
    typedef enum logic [3:0] {
        MODE_FAILSAFE = 4'b0001,
        MODE_NORMAL = 4'b0010,
        MODE_SILENT = 4'b0100,
        MODE_SLEEP = 4'b1000
    } mode_t;

    // Fail-safe source flags.
    typedef struct packed {
        logic bus_wake;
        logic local_wake;
        logic supply_uv;
    } fs_src_t;

    // Analog comparator indications.
    typedef struct packed {
        logic supply_uv;
        logic vreg_uv;
        logic over_temp;
    } analog_t;

endpackage

// ---- lin_sync2.sv ----
// Two-flip-flop synchroniser for asynchronous levels.
module lin_sync2 import lin_mode_pkg::*; #(
    parameter int unsigned W = 1,
    parameter logic [W-1:0] RST_VAL = '0
) (
    // Clock and reset.
    input wire logic i_clk,
    input wire logic i_resetn,
    // Asynchronous level in, synchronised level out.
    input wire logic [W-1:0] i_async,
    output logic [W-1:0] o_sync
);

    logic [W-1:0] meta_r;

    // The first stage feeds only the second stage.
    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            meta_r <= RST_VAL;
            o_sync <= RST_VAL;
        end else begin
            meta_r <= i_async;
            o_sync <= meta_r;
        end
    end

endmodule

// ---- lin_duration.sv ----
// Counter that reports when a level has stood for a given number of cycles.
module lin_duration import lin_mode_pkg::*; #(
    parameter int unsigned LIMIT = 500
) (
    // Clock and reset.
    input wire logic i_clk,
    input wire logic i_resetn,
    // Level to measure; the count restarts whenever it drops.
    input wire logic i_level,
    // High once the level has stood for more than LIMIT cycles.
    output logic o_done
);

    logic [CNT_W-1:0] cnt_r;

    // Counts while the level holds and saturates at the limit.
    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            cnt_r <= '0;
            o_done <= 1'b0;
        end else if (!i_level) begin
            cnt_r <= '0;
            o_done <= 1'b0;
        end else if (cnt_r < CNT_W'(LIMIT)) begin
            cnt_r <= cnt_r + CNT_W'(1);
            o_done <= 1'b0;
        end else begin
            o_done <= 1'b1;
        end
    end

endmodule

// ---- lin_far_side.sv ----
// Behavioural model of the host pins and the LIN bus facing the block.
module lin_far_side (
    // Device side.
    input wire logic i_drive_dom,
    input wire logic i_txd_dev,
    input wire logic i_txd_oe_n,
    // Host and bus stimulus.
    input wire logic i_short,
    input wire logic i_txd_host,
    input wire logic i_txd_host_en,
    input wire logic i_en_host,
    input wire logic i_en_host_en,
    // Resolved wire levels.
    output logic o_bus_rx,
    output logic o_txd_pin,
    output logic o_en_pin
);
    timeunit 1ns;
    timeprecision 1ns;

    // Bus is dominant when driven or shorted, else pulled recessive.
    assign o_bus_rx = !(i_drive_dom || i_short);
    // The device owns the transmit pin while its enable is low.
    assign o_txd_pin = !i_txd_oe_n ? i_txd_dev :
        (i_txd_host_en ? i_txd_host : 1'b1);
    // A released enable pin is pulled low.
    assign o_en_pin = i_en_host_en ? i_en_host : 1'b0;
endmodule

// ---- lin_mode_properties.sv ----
// Concurrent checks on the ports of the LIN mode control.
module lin_mode_properties import lin_mode_pkg::*; #(
    parameter int unsigned DOM_LIMIT = 500
) (
    // Clock and reset.
    input wire logic i_clk,
    input wire logic i_resetn,
    // Watched pins.
    input wire logic i_enable,
    input wire logic i_txd,
    input wire analog_t i_analog,
    input wire logic o_txd_oe_n,
    input wire logic o_rxd,
    input wire logic o_bus_drive_dom,
    input wire logic o_vreg_on,
    input wire logic o_internal_reset_n
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [CNT_W-1:0] dom_cnt_r;

    default clocking @(posedge i_clk); endclocking
    default disable iff (!i_resetn);

    // Counts how long the driver has stayed dominant.
    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            dom_cnt_r <= '0;
        end else if (!o_bus_drive_dom) begin
            dom_cnt_r <= '0;
        end else begin
            dom_cnt_r <= dom_cnt_r + 1'b1;
        end
    end

    // Enable drops while the transmit level has stood at t.
    sequence s_drop(logic t);
        (i_txd == t)[*3] ##0 $fell(i_enable) ##1
            (!i_enable && i_txd == t && o_internal_reset_n)[*5];
    endsequence

    a_start_safe: assert property ($rose(i_resetn) |->
        o_vreg_on && o_txd_oe_n && !o_bus_drive_dom)
        else $error("start state wrong");
    a_uv_blocks: assert property (i_analog.supply_uv[*5] |->
        !o_bus_drive_dom) else $error("drive during supply uv");
    a_hot_blocks: assert property (i_analog.over_temp[*5] |->
        !o_bus_drive_dom) else $error("drive during overtemp");
    a_vreg_reset: assert property (i_analog.vreg_uv[*4] |->
        !o_internal_reset_n) else $error("no internal reset");
    a_idle_high: assert property (i_txd[*4] |->
        !o_bus_drive_dom) else $error("drive with transmit high");
    a_dom_bound: assert property (dom_cnt_r <= DOM_LIMIT + 4)
        else $error("dominant too long");
    a_silent_rxd: assert property ((!i_enable && o_txd_oe_n)[*6] |->
        o_rxd) else $error("receive low while quiet");
    a_sleep_vreg: assert property (s_drop(1'b0) |->
        !o_vreg_on) else $error("regulator on in sleep");
    a_silent_vreg: assert property (s_drop(1'b1) |->
        o_vreg_on && !o_bus_drive_dom) else $error("silent state wrong");
endmodule

bind lin_mode_ctrl lin_mode_properties #(.DOM_LIMIT(DOM_LIMIT)) u_props (
    .i_clk(i_clk),
    .i_resetn(i_resetn),
    .i_enable(i_enable),
    .i_txd(i_txd),
    .i_analog(i_analog),
    .o_txd_oe_n(o_txd_oe_n),
    .o_rxd(o_rxd),
    .o_bus_drive_dom(o_bus_drive_dom),
    .o_vreg_on(o_vreg_on),
    .o_internal_reset_n(o_internal_reset_n)
);

// ---- testbench.sv ----
// Self-checking testbench of the LIN mode control.
module testbench;
    import lin_mode_pkg::*;
    timeunit 1ns;
    timeprecision 1ns;
    localparam int DL = 200;
    localparam int RL = 10;
    localparam int WL = 20;
    typedef struct packed {logic on; logic val; logic dom; logic rxd;} row_t;
    row_t rows [3] = '{4'ha, 4'hd, 4'h1};
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic en_h = 1'b0;
    logic en_on = 1'b1;
    logic txd_h = 1'b1;
    logic txd_on = 1'b1;
    logic wake_n = 1'b1;
    logic short_gnd = 1'b0;
    analog_t ana = '0;
    logic en_pin, txd_pin, bus_rx, txd_o, txd_oe_n, rxd, dom, vreg, int_rst_n;
    int miscompares = 0;
    int total_checks = 0;

    // Device under test with short counts and the far-side model.
    lin_mode_ctrl #(.DOM_LIMIT(DL), .REARM_LIMIT(RL), .WAKE_LIMIT(WL)) DUT (
        .i_clk(clk), .i_resetn(rst_n), .i_enable(en_pin), .i_txd(txd_pin),
        .o_txd(txd_o), .o_txd_oe_n(txd_oe_n), .o_rxd(rxd),
        .i_local_wake_input(wake_n), .i_bus_rx(bus_rx), .i_analog(ana),
        .o_bus_drive_dom(dom), .o_vreg_on(vreg),
        .o_internal_reset_n(int_rst_n));
    lin_far_side u_far (.i_drive_dom(dom), .i_txd_dev(txd_o),
        .i_txd_oe_n(txd_oe_n), .i_short(short_gnd), .i_txd_host(txd_h),
        .i_txd_host_en(txd_on), .i_en_host(en_h), .i_en_host_en(en_on),
        .o_bus_rx(bus_rx), .o_txd_pin(txd_pin), .o_en_pin(en_pin));

    // Clock generator, 20 ns period.
    initial forever #10 clk = ~clk;

    // Waits n edges, then the fixed drive delay.
    task step(int n);
        repeat (n) @(posedge clk);
        #2;
    endtask

    // Compares one seen bit against its expected value.
    task chk(logic s, logic e);
        total_checks++;
        if (s !== e) begin
            miscompares++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, s, e);
        end
    endtask

    // Prints the counts and the verdict, then stops.
    task close_out;
        $display("checks=%0d miscompares=%0d", total_checks, miscompares);
        if (miscompares == 0 && total_checks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    // Outputs expected while reset is held.
    task rst_chk;
        chk(dom, 1'b0);
        chk(vreg, 1'b1);
        chk(txd_oe_n, 1'b1);
        chk(int_rst_n, 1'b0);
        $display("test reset done");
    endtask

    // Cuts a hang short.
    initial begin
        repeat (4000) @(posedge clk);
        miscompares++;
        close_out();
    end

    // Main sequence.
    initial begin
        step(5);
        rst_chk();
        rst_n = 1'b1;
        step(8);
        chk(int_rst_n, 1'b1);
        en_h = 1'b1;
        step(RL + 16);
        foreach (rows[i]) begin
            txd_on = rows[i].on;
            txd_h = rows[i].val;
            step(8);
            chk(dom, rows[i].dom);
            chk(rxd, rows[i].rxd);
        end
        $display("test table done");
        txd_on = 1'b1;
        txd_h = 1'b0;
        step(DL + 12);
        chk(dom, 1'b0);
        txd_h = 1'b1;
        step(5);
        txd_h = 1'b0;
        step(8);
        chk(dom, 1'b0);
        txd_h = 1'b1;
        step(RL + 6);
        txd_h = 1'b0;
        step(8);
        chk(dom, 1'b1);
        $display("test timeout done");
        ana.supply_uv = 1'b1;
        step(8);
        chk(dom, 1'b0);
        chk(txd_oe_n, 1'b0);
        chk(txd_o, 1'b1);
        chk(rxd, 1'b0);
        ana.supply_uv = 1'b0;
        txd_h = 1'b1;
        en_h = 1'b0;
        step(8);
        chk(vreg, 1'b1);
        chk(rxd, 1'b1);
        chk(txd_oe_n, 1'b1);
        txd_h = 1'b0;
        step(2);
        en_h = 1'b1;
        step(8);
        chk(dom, 1'b0);
        txd_h = 1'b1;
        step(RL + 6);
        txd_h = 1'b0;
        step(8);
        chk(dom, 1'b1);
        $display("test silent done");
        step(DL + 4);
        chk(dom, 1'b0);
        en_h = 1'b0;
        step(8);
        chk(vreg, 1'b0);
        wake_n = 1'b0;
        step(WL + 12);
        chk(txd_oe_n, 1'b0);
        chk(txd_o, 1'b0);
        chk(rxd, 1'b1);
        wake_n = 1'b1;
        txd_h = 1'b1;
        en_h = 1'b1;
        step(RL + 16);
        chk(txd_oe_n, 1'b1);
        chk(vreg, 1'b1);
        $display("test wake done");
        en_h = 1'b0;
        step(8);
        short_gnd = 1'b1;
        step(WL + 12);
        chk(rxd, 1'b1);
        short_gnd = 1'b0;
        step(10);
        chk(txd_oe_n, 1'b0);
        chk(txd_o, 1'b0);
        chk(rxd, 1'b0);
        en_h = 1'b1;
        step(RL + 16);
        $display("test short done");
        txd_h = 1'b0;
        ana.over_temp = 1'b1;
        step(8);
        chk(dom, 1'b0);
        chk(vreg, 1'b1);
        ana.over_temp = 1'b0;
        step(8);
        chk(dom, 1'b1);
        txd_h = 1'b1;
        ana.vreg_uv = 1'b1;
        step(6);
        chk(int_rst_n, 1'b0);
        ana.vreg_uv = 1'b0;
        step(6);
        chk(int_rst_n, 1'b1);
        txd_h = 1'b0;
        step(8);
        en_on = 1'b0;
        step(8);
        chk(dom, 1'b0);
        $display("test fault done");
        rst_n = 1'b0;
        step(1);
        rst_chk();
        close_out();
    end
endmodule
